/* design/flash_self_rewrite_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "flash_self_rewrite_defines.svh"
module flash_self_rewrite_ctrl (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [15:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic high_speed_clk_i,
  input wire logic flash_done_i,
  output logic flash_req_o,
  output logic [1:0] flash_op_o,
  output logic [1:0] flash_seg_o,
  output logic [15:0] flash_addr_o,
  output logic [15:0] flash_wdata_o,
  output logic cpu_stall_o,
  output logic irq_hold_o
);
  flash_self_rewrite_pkg::ctrl_state_t r;
  flash_self_rewrite_pkg::ctrl_state_t next_r;
  logic wr_ok;
  logic target_ok;
  logic region_free;
  logic start_prog;
  logic start_block;
  logic start_sector;
  logic [1:0] region;

  assign wr_ok = sfr_wr_i &&
    (r.state == flash_self_rewrite_pkg::ST_IDLE);
  assign region = r.addr_hi[2:1];
  assign region_free = !r.protect[region];
  // Common permission for every trigger
  assign target_ok = r.self_on && r.armed && high_speed_clk_i &&
    (r.seg == `SEG_VALID) && (r.addr_hi[7:3] == 5'h00);
  assign start_prog = wr_ok && (sfr_addr_i == `OFS_DATA_HI) &&
    target_ok && region_free;
  assign start_block = wr_ok && (sfr_addr_i == `OFS_ERASE_CTL) &&
    sfr_wdata_i[`BIT_BLOCK_ERASE] && target_ok &&
    (r.protect == 4'h0);
  assign start_sector = wr_ok && (sfr_addr_i == `OFS_ERASE_CTL) &&
    !sfr_wdata_i[`BIT_BLOCK_ERASE] &&
    sfr_wdata_i[`BIT_SECTOR_ERASE] && target_ok &&
    region_free;

  always_comb begin
    next_r = r;
    if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        `OFS_ADDR_LO: next_r.rdata = r.addr_lo;
        `OFS_ADDR_HI: next_r.rdata = r.addr_hi;
        `OFS_DATA_LO: next_r.rdata = r.data_lo;
        `OFS_DATA_HI: next_r.rdata = r.data_hi;
        `OFS_SEGMENT: next_r.rdata = {6'h00, r.seg};
        `OFS_SELF_EN: next_r.rdata = {7'h00, r.self_on};
        `OFS_PROTECT: next_r.rdata = {4'h0, r.protect};
        default: next_r.rdata = 8'h00;
      endcase
    end
    if (wr_ok) begin
      unique case (sfr_addr_i)
        `OFS_ADDR_LO: next_r.addr_lo = {sfr_wdata_i[7:1], 1'h0};
        `OFS_ADDR_HI: next_r.addr_hi = sfr_wdata_i;
        `OFS_DATA_LO: next_r.data_lo = sfr_wdata_i;
        `OFS_DATA_HI: next_r.data_hi = sfr_wdata_i;
        `OFS_SEGMENT: next_r.seg = sfr_wdata_i[1:0];
        `OFS_SELF_EN: next_r.self_on = sfr_wdata_i[`BIT_SELF_ON];
        `OFS_PROTECT: next_r.protect = r.protect | sfr_wdata_i[3:0];
        `OFS_UNLOCK_KEY: begin
          if (sfr_wdata_i == `KEY_FIRST) begin
            next_r.key_half = 1'h1;
          end else if (r.key_half && sfr_wdata_i == `KEY_SECOND) begin
            next_r.key_half = 1'h0;
            next_r.armed = 1'h1;
          end else begin
            next_r.key_half = 1'h0;
          end
        end
        `OFS_ERASE_CTL: next_r.armed = 1'h0;
        default: next_r.rdata = next_r.rdata;
      endcase
      if (sfr_addr_i == `OFS_DATA_HI) begin
        next_r.armed = 1'h0;
      end
    end
    unique case (r.state)
      flash_self_rewrite_pkg::ST_IDLE: begin
        if (start_block) begin
          next_r.op = flash_self_rewrite_pkg::OP_BLOCK;
          next_r.erase_ctl = 2'h1;
        end else if (start_sector) begin
          next_r.op = flash_self_rewrite_pkg::OP_SECTOR;
          next_r.erase_ctl = 2'h2;
        end else if (start_prog) begin
          next_r.op = flash_self_rewrite_pkg::OP_PROG;
        end
        if (start_block || start_sector || start_prog) begin
          next_r.state = flash_self_rewrite_pkg::ST_RUN;
          next_r.req = 1'h1;
        end
      end
      flash_self_rewrite_pkg::ST_RUN: begin
        if (flash_done_i) begin
          next_r.state = flash_self_rewrite_pkg::ST_END;
          next_r.req = 1'h0;
          next_r.erase_ctl = 2'h0;
        end
      end
      flash_self_rewrite_pkg::ST_END: begin
        next_r.state = flash_self_rewrite_pkg::ST_IDLE;
        next_r.op = flash_self_rewrite_pkg::OP_NONE;
      end
      default: begin
        next_r.state = flash_self_rewrite_pkg::ST_IDLE;
        next_r.req = 1'h0;
      end
    endcase
    next_r.stall = (next_r.state != flash_self_rewrite_pkg::ST_IDLE);
    next_r.hold = next_r.stall;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r.addr_lo <= `RST_BYTE;
      r.addr_hi <= `RST_BYTE;
      r.data_lo <= `RST_BYTE;
      r.data_hi <= `RST_BYTE;
      r.seg <= `RST_SEG;
      r.self_on <= 1'h0;
      r.protect <= `RST_PROT;
      r.key_half <= 1'h0;
      r.armed <= 1'h0;
      r.erase_ctl <= 2'h0;
      r.op <= flash_self_rewrite_pkg::OP_NONE;
      r.state <= flash_self_rewrite_pkg::ST_IDLE;
      r.req <= 1'h0;
      r.stall <= 1'h0;
      r.hold <= 1'h0;
      r.rdata <= `RST_BYTE;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign sfr_rdata_o = r.rdata;
  assign flash_req_o = r.req;
  assign flash_op_o = r.op;
  assign flash_seg_o = r.seg;
  assign flash_addr_o = {r.addr_hi, r.addr_lo};
  assign flash_wdata_o = {r.data_hi, r.data_lo};
  assign cpu_stall_o = r.stall;
  assign irq_hold_o = r.hold;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i || !ce_i);

  sequence s_key_write(logic [7:0] v);
    sfr_wr_i && sfr_addr_i == `OFS_UNLOCK_KEY && sfr_wdata_i == v &&
      r.state == flash_self_rewrite_pkg::ST_IDLE;
  endsequence
  sequence s_idle_write(logic [15:0] a);
    sfr_wr_i && sfr_addr_i == a &&
      r.state == flash_self_rewrite_pkg::ST_IDLE;
  endsequence

  property p_addr_even;
    !flash_addr_o[0];
  endproperty
  a_addr_even: assert property (p_addr_even)
    else $error("address bit 0 set");

  property p_prog_start;
    s_idle_write(`OFS_DATA_HI) ##0 target_ok && region_free |=>
      flash_req_o && flash_op_o == flash_self_rewrite_pkg::OP_PROG &&
      flash_wdata_o[15:8] == $past(sfr_wdata_i);
  endproperty
  a_prog_start: assert property (p_prog_start)
    else $error("word program did not start");

  property p_stall_cover;
    flash_req_o |-> cpu_stall_o && irq_hold_o;
  endproperty
  a_stall_cover: assert property (p_stall_cover)
    else $error("request without stall");

  property p_end_resume;
    flash_req_o && flash_done_i |=> !flash_req_o && cpu_stall_o
      ##1 !cpu_stall_o && !irq_hold_o && r.erase_ctl == 2'h0;
  endproperty
  a_end_resume: assert property (p_end_resume)
    else $error("no resume two cycles after done");

  property p_block_wins;
    s_idle_write(`OFS_ERASE_CTL) ##0 sfr_wdata_i[1:0] == 2'h3 &&
      target_ok && r.protect == 4'h0 |=>
      flash_op_o == flash_self_rewrite_pkg::OP_BLOCK;
  endproperty
  a_block_wins: assert property (p_block_wins)
    else $error("block erase not chosen");

  property p_unlock_arms;
    s_key_write(`KEY_SECOND) ##0 r.key_half |=> r.armed;
  endproperty
  a_unlock_arms: assert property (p_unlock_arms)
    else $error("unlock did not arm");

  property p_bad_key;
    r.key_half ##0 sfr_wr_i && sfr_addr_i == `OFS_UNLOCK_KEY &&
      sfr_wdata_i != `KEY_SECOND && sfr_wdata_i != `KEY_FIRST &&
      r.state == flash_self_rewrite_pkg::ST_IDLE |=> !r.key_half;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("partial unlock kept");

  property p_protect_sticky;
    r.protect != 4'h0 |=> (r.protect & $past(r.protect)) ==
      $past(r.protect);
  endproperty
  a_protect_sticky: assert property (p_protect_sticky)
    else $error("protect bit cleared");

  property p_no_start_disabled;
    !flash_req_o && (!r.self_on || !r.armed ||
      r.seg != `SEG_VALID) |=> !flash_req_o;
  endproperty
  a_no_start_disabled: assert property (p_no_start_disabled)
    else $error("start without permission");

  property p_consume;
    s_key_write(`KEY_SECOND) ##0 r.key_half ##1
      s_idle_write(`OFS_ERASE_CTL) |=> !r.armed;
  endproperty
  a_consume: assert property (p_consume)
    else $error("unlock not consumed");

  property p_rd_zero;
    sfr_rd_i && (sfr_addr_i == `OFS_ERASE_CTL ||
      sfr_addr_i == `OFS_UNLOCK_KEY) |=> sfr_rdata_o == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("write-only register read nonzero");

  property p_addr_lo_write;
    s_idle_write(`OFS_ADDR_LO) |=>
      flash_addr_o[7:0] == ($past(sfr_wdata_i) & 8'hFE);
  endproperty
  a_addr_lo_write: assert property (p_addr_lo_write)
    else $error("low address byte wrong");

  property p_addr_hi_write;
    s_idle_write(`OFS_ADDR_HI) |=>
      flash_addr_o[15:8] == $past(sfr_wdata_i);
  endproperty
  a_addr_hi_write: assert property (p_addr_hi_write)
    else $error("upper address byte wrong");

  property p_data_lo_write;
    s_idle_write(`OFS_DATA_LO) |=>
      flash_wdata_o[7:0] == $past(sfr_wdata_i) && !flash_req_o;
  endproperty
  a_data_lo_write: assert property (p_data_lo_write)
    else $error("low data byte wrong or started");

  property p_seg_write;
    s_idle_write(`OFS_SEGMENT) |=>
      flash_seg_o == $past(sfr_wdata_i[1:0]);
  endproperty
  a_seg_write: assert property (p_seg_write)
    else $error("segment field wrong");

  property p_self_write;
    s_idle_write(`OFS_SELF_EN) |=>
      r.self_on == $past(sfr_wdata_i[`BIT_SELF_ON]);
  endproperty
  a_self_write: assert property (p_self_write)
    else $error("self-rewrite enable wrong");

  property p_sector_start;
    s_idle_write(`OFS_ERASE_CTL) ##0 sfr_wdata_i[1:0] == 2'h2 &&
      target_ok && region_free |=>
      flash_req_o && flash_op_o == flash_self_rewrite_pkg::OP_SECTOR;
  endproperty
  a_sector_start: assert property (p_sector_start)
    else $error("sector erase did not start");

  property p_req_hold;
    flash_req_o && !flash_done_i |=> flash_req_o && $stable(flash_op_o);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request dropped before done");

  property p_low_clock;
    !flash_req_o && !high_speed_clk_i |=> !flash_req_o;
  endproperty
  a_low_clock: assert property (p_low_clock)
    else $error("start on low-speed clock");

  property p_key_gap;
    s_key_write(`KEY_FIRST) ##2 s_idle_write(`OFS_ADDR_HI) ##2
      s_key_write(`KEY_SECOND) |=> r.armed;
  endproperty
  a_key_gap: assert property (p_key_gap)
    else $error("unlock lost across other write");

  property p_prog_protected;
    s_idle_write(`OFS_DATA_HI) ##0 !region_free |=> !flash_req_o;
  endproperty
  a_prog_protected: assert property (p_prog_protected)
    else $error("word write to protected region");

  property p_block_protected;
    s_idle_write(`OFS_ERASE_CTL) ##0 sfr_wdata_i[`BIT_BLOCK_ERASE] &&
      r.protect != 4'h0 |=> !flash_req_o;
  endproperty
  a_block_protected: assert property (p_block_protected)
    else $error("block erase despite protection");
endmodule
`default_nettype wire

/* design/flash_self_rewrite_defines.svh */
// What this block does
// - Address bit 0 stays zero, unwritable
// - Upper byte plus segment selects target
// - High data byte write starts word program
// - CPU stalled during word program
// - Peripherals run, interrupts held while busy
// - Control bit 0 starts block erase, wins
// - Control bit 1 alone starts sector erase
// - Erase bits self-clear at end; write-only
// - CPU stalled during erase
// - Key pair arms exactly one operation
// - Other instructions between key writes allowed
// - Wrong second key discards partial unlock
// - Only segment code 10 is valid
// - Self-rewrite enable bit gates function
// - Sector erase clears 512-byte region
// - Block erase clears all four regions
// - Protect bits sticky, block region operations
// - No rewrite without high-speed clock
`ifndef FLASH_SELF_REWRITE_DEFINES_SVH
`define FLASH_SELF_REWRITE_DEFINES_SVH
`define OFS_ADDR_LO 16'hF0E0
`define OFS_ADDR_HI 16'hF0E1
`define OFS_DATA_LO 16'hF0E2
`define OFS_DATA_HI 16'hF0E3
`define OFS_ERASE_CTL 16'hF0E4
`define OFS_UNLOCK_KEY 16'hF0E5
`define OFS_SEGMENT 16'hF0E6
`define OFS_SELF_EN 16'hF0E7
`define OFS_PROTECT 16'hF0E8
`define RST_BYTE 8'h00
`define RST_SEG 2'h0
`define RST_PROT 4'h0
`define KEY_FIRST 8'hFA
`define KEY_SECOND 8'hF5
`define SEG_VALID 2'h2
`define BIT_BLOCK_ERASE 0
`define BIT_SECTOR_ERASE 1
`define BIT_SELF_ON 0
`endif

/* design/flash_self_rewrite_pkg.sv */
package flash_self_rewrite_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_END = 2'h3
  } state_t;
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_PROG = 2'h1,
    OP_SECTOR = 2'h2,
    OP_BLOCK = 2'h3
  } op_t;
  typedef struct packed {
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic [1:0] seg;
    logic self_on;
    logic [3:0] protect;
    logic key_half;
    logic armed;
    logic [1:0] erase_ctl;
    op_t op;
    state_t state;
    logic req;
    logic stall;
    logic hold;
    logic [7:0] rdata;
  } ctrl_state_t;
endpackage

/* bench/flash_array_model.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic flash_req_i,
  input wire logic [7:0] lat_i,
  output logic flash_done_o
);
  logic [7:0] cnt;
  // One done pulse a set number of cycles into each request
  always_ff @(posedge clk_i) begin
    if (reset_i || !flash_req_i || flash_done_o) begin
      cnt <= 8'h00;
      flash_done_o <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
      flash_done_o <= (cnt == lat_i);
    end
  end
endmodule
`default_nettype wire

/* bench/flash_self_rewrite_ctrl_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module flash_self_rewrite_ctrl_test;
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic [15:0] sa = 16'h0000;
  logic sw = 1'h0;
  logic sr = 1'h0;
  logic [7:0] sd = 8'h00;
  logic hs = 1'h1;
  logic ce = 1'h1;
  logic [7:0] lat = 8'h02;
  logic done, req, stall, hold;
  logic [7:0] rdata;
  logic [1:0] op, seg;
  logic [15:0] addr, wdata;
  int n_errors = 0;
  int check_count = 0;
  always #5 clk_i = ~clk_i;
  flash_self_rewrite_ctrl dut_u (.clk_i(clk_i), .reset_i(reset_i),
    .ce_i(ce), .sfr_addr_i(sa), .sfr_wr_i(sw), .sfr_rd_i(sr),
    .sfr_wdata_i(sd), .sfr_rdata_o(rdata), .high_speed_clk_i(hs),
    .flash_done_i(done), .flash_req_o(req), .flash_op_o(op),
    .flash_seg_o(seg), .flash_addr_o(addr), .flash_wdata_o(wdata),
    .cpu_stall_o(stall), .irq_hold_o(hold));
  flash_array_model far_u (.clk_i(clk_i), .reset_i(reset_i),
    .flash_req_i(req), .lat_i(lat), .flash_done_o(done));
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    sa <= a;
    sd <= d;
    sw <= 1'h1;
    @(posedge clk_i);
    sw <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    sa <= a;
    sr <= 1'h1;
    @(posedge clk_i);
    sr <= 1'h0;
    @(posedge clk_i);
    `CHK(rdata, e)
  endtask
  task automatic key();
    wr(16'hF0E5, 8'hFA);
    wr(16'hF0E5, 8'hF5);
  endtask
  // Trigger write, check start, then wait for the stall to end
  task automatic go(input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] e);
    int i;
    wr(a, d);
    `CHK(op, e)
    `CHK(req, e != 2'h0)
    `CHK(stall, e != 2'h0)
    `CHK(hold, e != 2'h0)
    for (i = 0; i < 200 && stall !== 1'h0; i++) @(posedge clk_i);
    if (stall !== 1'h0) begin
      n_errors++;
      final_report();
    end
    `CHK(op, 2'h0)
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'h0;
    @(posedge clk_i);
    for (int i = 0; i < 10; i++) rd(16'hF0E0 + i[15:0], 8'h00);
    wr(16'hF0E0, 8'hFF);
    rd(16'hF0E0, 8'hFE);
    wr(16'hF0E4, 8'h01);
    rd(16'hF0E4, 8'h00);
    wr(16'hF0E7, 8'h01);
    rd(16'hF0E7, 8'h01);
    wr(16'hF0E6, 8'h02);
    rd(16'hF0E6, 8'h02);
    tend("registers");
    wr(16'hF0E1, 8'h02);
    key();
    go(16'hF0E4, 8'h02, 2'h2);
    wr(16'hF0E2, 8'h34);
    key();
    go(16'hF0E3, 8'h12, 2'h1);
    `CHK(addr, 16'h02FE)
    `CHK(wdata, 16'h1234)
    `CHK(seg, 2'h2)
    go(16'hF0E3, 8'h12, 2'h0);
    ce <= 1'h0;
    wr(16'hF0E2, 8'hAA);
    ce <= 1'h1;
    rd(16'hF0E2, 8'h34);
    tend("program");
    wr(16'hF0E5, 8'hFA);
    wr(16'hF0E5, 8'h00);
    wr(16'hF0E5, 8'hF5);
    go(16'hF0E4, 8'h01, 2'h0);
    wr(16'hF0E5, 8'hFA);
    wr(16'hF0E1, 8'h00);
    wr(16'hF0E5, 8'hF5);
    lat <= 8'h30;
    go(16'hF0E4, 8'h03, 2'h3);
    lat <= 8'h02;
    key();
    go(16'hF0E4, 8'h02, 2'h2);
    tend("erase");
    hs <= 1'h0;
    key();
    go(16'hF0E4, 8'h02, 2'h0);
    hs <= 1'h1;
    wr(16'hF0E6, 8'h01);
    key();
    go(16'hF0E4, 8'h02, 2'h0);
    wr(16'hF0E6, 8'h02);
    wr(16'hF0E7, 8'h00);
    key();
    go(16'hF0E3, 8'h55, 2'h0);
    wr(16'hF0E7, 8'h01);
    tend("refusals");
    wr(16'hF0E8, 8'h01);
    wr(16'hF0E8, 8'h00);
    rd(16'hF0E8, 8'h01);
    key();
    go(16'hF0E4, 8'h02, 2'h0);
    wr(16'hF0E1, 8'h02);
    key();
    go(16'hF0E4, 8'h02, 2'h2);
    key();
    go(16'hF0E4, 8'h01, 2'h0);
    wr(16'hF0E1, 8'h00);
    key();
    go(16'hF0E3, 8'h77, 2'h0);
    tend("protect");
    reset_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'h0;
    @(posedge clk_i);
    rd(16'hF0E8, 8'h00);
    rd(16'hF0E7, 8'h00);
    tend("reset");
    final_report();
  end
endmodule
`default_nettype wire
